// File: rtl/aoc_defs.svh
`ifndef AOC_DEFS_SVH
`define AOC_DEFS_SVH

// Rate of the system clock and the seconds tick derived from it.
`define AOC_CLK_HZ        250000000
`define AOC_TICK_S        1
// Longest output timing setting, in seconds.
`define AOC_TIME_MAX_S    999
// Output modes.
`define AOC_MODE_OFF      2'h0
`define AOC_MODE_NO       2'h1
`define AOC_MODE_NC       2'h2
// Channel source selections.
`define AOC_SRC_NONE      3'h0
`define AOC_SRC_A1        3'h1
`define AOC_SRC_A2        3'h2
`define AOC_SRC_EITHER    3'h3
`define AOC_SRC_BOTH      3'h4
// Logic function.
`define AOC_FUNC_OR       1'h0
`define AOC_FUNC_AND      1'h1

`endif

// File: rtl/aoc_pkg.sv
package aoc_pkg;
    typedef enum logic [3:0] {
        AOC_ST_OPEN       = 4'h1,
        AOC_ST_CLOSE_WAIT = 4'h2,
        AOC_ST_CLOSED     = 4'h4,
        AOC_ST_OPEN_WAIT  = 4'h8
    } aoc_state_t;
endpackage

// File: rtl/aoc_alarm.sv
`timescale 1ns/100ps
`default_nettype none
`include "aoc_defs.svh"

// =====================================================================
// One threshold comparator with hysteresis
// =====================================================================
module aoc_alarm #(
    parameter int W = 16
) (
    input  wire logic         sys_clk_i,   // System clock
    input  wire logic         rst_n_i,     // Synchronised reset, low
    input  wire logic         sample_i,    // New measurement strobe
    input  wire logic [W-1:0] value_i,     // Displayed value, signed
    input  wire logic [W-1:0] thresh_i,    // Threshold, signed
    input  wire logic [W-1:0] hyst_i,      // Hysteresis, unsigned
    input  wire logic         under_i,     // One for under direction
    output logic              alarm_o      // Alarm state
);
    logic              alarm;
    logic              next_alarm;
    logic signed [W+1:0] v;
    logic signed [W+1:0] hi;
    logic signed [W+1:0] lo;

    // Widened so that thresholds near the range ends cannot wrap; no
    // range check is made, so such thresholds just pin the alarm.
    assign v  = (W+2)'(signed'(value_i));
    assign hi = (W+2)'(signed'(thresh_i)) + (W+2)'({2'h0, hyst_i});
    assign lo = (W+2)'(signed'(thresh_i)) - (W+2)'({2'h0, hyst_i});

    always_comb begin
        next_alarm = alarm;
        if (sample_i) begin
            if (!under_i) begin
                if (v > hi)
                    next_alarm = 1'b1;
                else if (v < lo || hyst_i == '0)
                    next_alarm = 1'b0;
            end else begin
                if (v < lo)
                    next_alarm = 1'b1;
                else if (v > hi || hyst_i == '0)
                    next_alarm = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            alarm <= 1'b0;
        else
            alarm <= next_alarm;
    end

    assign alarm_o = alarm;
endmodule
`default_nettype wire

// File: rtl/aoc_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "aoc_defs.svh"

module aoc_top import aoc_pkg::*; #(
    parameter int NCH      = 8,
    parameter int NOUT     = 2,
    parameter int W        = 16,
    parameter int TW       = 10,
    parameter int TICK_CYC = `AOC_CLK_HZ * `AOC_TICK_S
) (
    input  wire logic                sys_clk_i,     // 250 MHz clock
    input  wire logic                reset_n_i,     // Async reset, low
    input  wire logic                sample_i,      // New result strobe
    input  wire logic [NCH*W-1:0]    value_i,       // Values per channel
    input  wire logic [NCH*W-1:0]    thresh1_i,     // First thresholds
    input  wire logic [NCH*W-1:0]    thresh2_i,     // Second thresholds
    input  wire logic [NCH*W-1:0]    hyst1_i,       // First hysteresis
    input  wire logic [NCH*W-1:0]    hyst2_i,       // Second hysteresis
    input  wire logic [NCH-1:0]      first_alarm_direction_i,  // 1 under
    input  wire logic [NCH-1:0]      second_alarm_direction_i, // 1 under
    input  wire logic [NOUT*2-1:0]   mode_i,        // Output modes
    input  wire logic [NOUT-1:0]     func_i,        // 0 OR, 1 AND
    input  wire logic [NOUT*NCH*3-1:0] source_i,    // Source selections
    input  wire logic [NOUT*TW-1:0]  close_dly_i,   // Close delay, s
    input  wire logic [NOUT*TW-1:0]  open_dly_i,    // Open delay, s
    input  wire logic [NOUT*TW-1:0]  close_hold_i,  // Closed hold, s
    input  wire logic [NOUT*TW-1:0]  open_hold_i,   // Open hold, s
    output logic      [NCH-1:0]      alarm1_o,      // First alarms
    output logic      [NCH-1:0]      alarm2_o,      // Second alarms
    output logic      [NOUT-1:0]     active_o,      // Logical active
    output logic      [NOUT-1:0]     contact_o      // 1 contact closed
);
    // =================================================================
    // Reset release and seconds tick
    // =================================================================
    logic [1:0]  rst_sync;
    logic        rst_n;
    logic [31:0] tick_cnt;
    logic [31:0] next_tick_cnt;
    logic        tick;
    logic        next_tick;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    always_comb begin
        next_tick     = 1'b0;
        next_tick_cnt = tick_cnt + 32'h1;
        if (tick_cnt >= 32'(TICK_CYC - 1)) begin
            next_tick_cnt = 32'h0;
            next_tick     = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= 32'h0;
            tick     <= 1'b0;
        end else begin
            tick_cnt <= next_tick_cnt;
            tick     <= next_tick;
        end
    end

    // =================================================================
    // Channel alarms
    // =================================================================
    logic [NCH-1:0] al1;
    logic [NCH-1:0] al2;

    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            // Two independent comparators per channel.
            aoc_alarm #(.W(W)) u_a1 (
                .sys_clk_i (sys_clk_i),
                .rst_n_i   (rst_n),
                .sample_i  (sample_i),
                .value_i   (value_i[c*W +: W]),
                .thresh_i  (thresh1_i[c*W +: W]),
                .hyst_i    (hyst1_i[c*W +: W]),
                .under_i   (first_alarm_direction_i[c]),
                .alarm_o   (al1[c])
            );
            aoc_alarm #(.W(W)) u_a2 (
                .sys_clk_i (sys_clk_i),
                .rst_n_i   (rst_n),
                .sample_i  (sample_i),
                .value_i   (value_i[c*W +: W]),
                .thresh_i  (thresh2_i[c*W +: W]),
                .hyst_i    (hyst2_i[c*W +: W]),
                .under_i   (second_alarm_direction_i[c]),
                .alarm_o   (al2[c])
            );
        end
    endgenerate

    // =================================================================
    // Outputs
    // =================================================================
    genvar o;
    generate
        for (o = 0; o < NOUT; o++) begin : g_out
            logic [NCH-1:0] hit;
            logic [NCH-1:0] used;
            logic           cond;
            logic           want;
            logic [1:0]     mode;
            aoc_state_t     st;
            aoc_state_t     next_st;
            logic [TW:0]    acc;
            logic [TW:0]    next_acc;
            logic [TW-1:0]  hold;
            logic [TW-1:0]  next_hold;
            logic           act;
            logic           next_act;
            logic           con;
            logic           next_con;
            logic [TW-1:0]  cdly;
            logic [TW-1:0]  odly;

            assign mode = mode_i[o*2 +: 2];
            assign cdly = close_dly_i[o*TW +: TW];
            assign odly = open_dly_i[o*TW +: TW];

            always_comb begin
                for (int k = 0; k < NCH; k++) begin
                    used[k] = 1'b1;
                    case (source_i[(o*NCH+k)*3 +: 3])
                        `AOC_SRC_A1:     hit[k] = al1[k];
                        `AOC_SRC_A2:     hit[k] = al2[k];
                        `AOC_SRC_EITHER: hit[k] = al1[k] | al2[k];
                        `AOC_SRC_BOTH:   hit[k] = al1[k] & al2[k];
                        default: begin
                            hit[k]  = 1'b0;
                            used[k] = 1'b0;
                        end
                    endcase
                end
                if (func_i[o] == `AOC_FUNC_AND)
                    // Ignored channels do not block AND; none attached
                    // means never active.
                    cond = (used != '0) && ((hit | ~used) == '1);
                else
                    cond = (hit != '0);
                want = cond && (mode != `AOC_MODE_OFF);
            end

            // The delay is an up/down integrator: it counts up each second
            // the condition stands and down each second it lapses, so a
            // condition above half duty still reaches the delay.
            always_comb begin
                next_st   = st;
                next_acc  = acc;
                next_hold = hold;
                next_act  = act;
                if (tick && hold != '0)
                    next_hold = hold - 1'b1;
                case (st)
                    AOC_ST_OPEN: begin
                        next_acc = '0;
                        if (want && hold == '0) begin
                            if (cdly == '0) begin
                                next_st   = AOC_ST_CLOSED;
                                next_act  = 1'b1;
                                next_hold = close_hold_i[o*TW +: TW];
                            end else
                                next_st = AOC_ST_CLOSE_WAIT;
                        end
                    end
                    AOC_ST_CLOSE_WAIT: begin
                        if (tick) begin
                            if (want)
                                next_acc = acc + 1'b1;
                            else if (acc != '0)
                                next_acc = acc - 1'b1;
                            else
                                next_st = AOC_ST_OPEN;
                            if (want && acc + 1'b1 >= {1'b0, cdly}) begin
                                next_st   = AOC_ST_CLOSED;
                                next_act  = 1'b1;
                                next_hold = close_hold_i[o*TW +: TW];
                            end
                        end
                    end
                    AOC_ST_CLOSED: begin
                        next_acc = '0;
                        if (!want && hold == '0) begin
                            if (odly == '0) begin
                                next_st   = AOC_ST_OPEN;
                                next_act  = 1'b0;
                                next_hold = open_hold_i[o*TW +: TW];
                            end else
                                next_st = AOC_ST_OPEN_WAIT;
                        end
                    end
                    AOC_ST_OPEN_WAIT: begin
                        if (tick) begin
                            if (!want)
                                next_acc = acc + 1'b1;
                            else if (acc != '0)
                                next_acc = acc - 1'b1;
                            else
                                next_st = AOC_ST_CLOSED;
                            if (!want && acc + 1'b1 >= {1'b0, odly}) begin
                                next_st   = AOC_ST_OPEN;
                                next_act  = 1'b0;
                                next_hold = open_hold_i[o*TW +: TW];
                            end
                        end
                    end
                    default: begin
                        next_st  = AOC_ST_OPEN;
                        next_acc = '0;
                        next_act = 1'b0;
                    end
                endcase
                // Timings count whole seconds of the tick.
                if (mode == `AOC_MODE_OFF)
                    next_con = 1'b0;
                else if (mode == `AOC_MODE_NC)
                    next_con = ~next_act;
                else
                    next_con = next_act;
            end

            always_ff @(posedge sys_clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    st   <= AOC_ST_OPEN;
                    acc  <= '0;
                    hold <= '0;
                    act  <= 1'b0;
                    con  <= 1'b0;
                end else begin
                    st   <= next_st;
                    acc  <= next_acc;
                    hold <= next_hold;
                    act  <= next_act;
                    con  <= next_con;
                end
            end
        end
    endgenerate

    // =================================================================
    // Registered outputs
    // =================================================================
    logic [NOUT-1:0] act_all;
    logic [NOUT-1:0] con_all;
    generate
        for (o = 0; o < NOUT; o++) begin : g_col
            assign act_all[o] = g_out[o].act;
            assign con_all[o] = g_out[o].con;
        end
    endgenerate

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            alarm1_o  <= '0;
            alarm2_o  <= '0;
            active_o  <= '0;
            contact_o <= '0;
        end else begin
            alarm1_o  <= al1;
            alarm2_o  <= al2;
            active_o  <= act_all;
            contact_o <= con_all;
        end
    end
endmodule
`default_nettype wire

// File: tb/aoc_checker.sv
`timescale 1ns/100ps
`default_nettype none

// ==================================================================
// Port checker for the alarm output block
// ==================================================================
module aoc_chk #(
    parameter int NCH      = 8,
    parameter int NOUT     = 2,
    parameter int W        = 16,
    parameter int TW       = 10,
    parameter int TICK_CYC = 10
) (
    input wire logic                  sys_clk_i,    // Clock
    input wire logic                  reset_n_i,    // Reset, low
    input wire logic                  sample_i,     // Result strobe
    input wire logic [NCH*W-1:0]      value_i,      // Values
    input wire logic [NCH*W-1:0]      thresh1_i,    // First thresholds
    input wire logic [NCH*W-1:0]      hyst1_i,      // First hysteresis
    input wire logic [NCH-1:0]        first_alarm_direction_i, // 1 under
    input wire logic [NOUT*2-1:0]     mode_i,       // Modes
    input wire logic [NOUT-1:0]       func_i,       // 1 AND
    input wire logic [NOUT*NCH*3-1:0] source_i,     // Sources
    input wire logic [NOUT*TW-1:0]    close_dly_i,  // Close delays
    input wire logic [NOUT*TW-1:0]    close_hold_i, // Closed holds
    input wire logic [NOUT*TW-1:0]    open_hold_i,  // Open holds
    input wire logic [NCH-1:0]        alarm1_o,     // First alarms
    input wire logic [NCH-1:0]        alarm2_o,     // Second alarms
    input wire logic [NOUT-1:0]       active_o,     // Active states
    input wire logic [NOUT-1:0]       contact_o     // Contacts
);
    logic signed [W+1:0] v0;
    logic signed [W+1:0] hi0;
    logic signed [W+1:0] lo0;
    logic                dn0;
    int                  since_sw;

    // Two spare bits keep threshold plus hysteresis from wrapping.
    assign v0  = $signed(value_i[W-1:0]);
    assign hi0 = $signed(thresh1_i[W-1:0]) + $signed({2'h0, hyst1_i[W-1:0]});
    assign lo0 = $signed(thresh1_i[W-1:0]) - $signed({2'h0, hyst1_i[W-1:0]});
    assign dn0 = first_alarm_direction_i[0];

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            since_sw <= 0;
        end else if ($changed(active_o[1])) begin
            since_sw <= 0;
        end else begin
            since_sw <= since_sw + 1;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_mode(logic [1:0] m);
        (mode_i[1:0] == m)[*4];
    endsequence

    chk_sample_only: assert property (
        !$past(sample_i, 2) |-> $stable(alarm1_o) && $stable(alarm2_o))
        else $error("alarm changed without a sample");
    chk_over_set: assert property (
        sample_i && !dn0 && v0 > hi0 |-> ##2 alarm1_o[0])
        else $error("over alarm not raised");
    chk_over_clr: assert property (
        sample_i && !dn0 && v0 < lo0 |-> ##2 !alarm1_o[0])
        else $error("over alarm not cleared");
    chk_under_set: assert property (
        sample_i && dn0 && v0 < lo0 |-> ##2 alarm1_o[0])
        else $error("under alarm not raised");
    chk_off_open: assert property (
        s_mode(2'h0) |-> !contact_o[0])
        else $error("inactive output not open");
    chk_no_map: assert property (
        s_mode(2'h1) |-> contact_o[0] == active_o[0])
        else $error("normally open contact wrong");
    chk_nc_map: assert property (
        s_mode(2'h2) |-> contact_o[0] == !active_o[0])
        else $error("normally closed contact wrong");
    chk_or_follow: assert property (
        $rose(alarm1_o[0]) && !func_i[0] && source_i[5:0] == 6'h01
        && mode_i[1:0] != 2'h0
        && close_dly_i[TW-1:0] == 0 && close_hold_i[TW-1:0] == 0
        && open_hold_i[TW-1:0] == 0 |-> ##[1:3] active_o[0])
        else $error("output did not follow alarm");
    chk_and_all: assert property (
        $rose(active_o[0]) && func_i[0] && source_i[5:0] == 6'h11
        |-> $past(alarm1_o[0] && alarm2_o[1]))
        else $error("and output active without all alarms");
    chk_hold_closed: assert property (
        close_hold_i[2*TW-1:TW] > 1 && $fell(active_o[1]) |-> since_sw
        >= (int'(close_hold_i[2*TW-1:TW]) - 1) * TICK_CYC - 2)
        else $error("closed hold cut short");
endmodule

bind aoc_top aoc_chk #(.NCH(NCH), .NOUT(NOUT), .W(W), .TW(TW),
    .TICK_CYC(TICK_CYC)) i_chk (.sys_clk_i, .reset_n_i, .sample_i,
    .value_i, .thresh1_i, .hyst1_i, .first_alarm_direction_i, .mode_i,
    .func_i, .source_i, .close_dly_i, .close_hold_i, .open_hold_i,
    .alarm1_o, .alarm2_o, .active_o, .contact_o);

`default_nettype wire

// File: tb/aoc_meas_model.sv
`timescale 1ns/100ps
`default_nettype none

// ==================================================================
// Measurement chain publishing one result per request
// ==================================================================
module aoc_meas_model #(
    parameter int NCH = 2,
    parameter int W   = 16
) (
    input  wire logic             sys_clk_i, // Clock
    input  wire logic             go_i,      // Publish a result
    input  wire logic [NCH*W-1:0] req_val_i, // Values to publish
    output logic                  sample_o,  // Result strobe
    output logic      [NCH*W-1:0] value_o    // Displayed values
);
    // Value and strobe move together, so a strobe never sees stale data.
    always @(posedge sys_clk_i) begin
        sample_o <= go_i;
        if (go_i) begin
            value_o <= req_val_i;
        end
    end
endmodule

`default_nettype wire

// File: tb/aoc_top_bench.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        fail_count++; \
        $display("ERROR %0t: got %h want %h", $time, got, exp); \
    end

// ==================================================================
// Directed bench for the alarm output block
// ==================================================================
module aoc_top_bench;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        go = 1'b0;
    logic        sample;
    logic [31:0] req = 32'h0;
    logic [31:0] val;
    logic [31:0] thr1 = {16'h7FFF, 16'h0064};
    logic [31:0] thr2 = {16'h0064, 16'h0078};
    logic [31:0] hy1 = 32'h0;
    logic [31:0] hy2 = 32'h0;
    logic [1:0]  dir1 = 2'h0;
    logic [1:0]  dir2 = 2'h0;
    logic [3:0]  mode = 4'h5;
    logic [1:0]  func = 2'h0;
    logic [11:0] src = 12'h001;
    logic [19:0] cdly = 20'h0;
    logic [19:0] odly = 20'h0;
    logic [19:0] chold = 20'h0;
    logic [19:0] ohold = 20'h0;
    logic [1:0]  al1, al2, act, cont;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          n;
    int          hv[9] = '{50, 150, 105, 95, 89, 105, 111, 90, 100};
    int          hh[9] = '{0, 0, 10, 10, 10, 10, 10, 0, 0};
    logic        hd[9] = '{0, 0, 0, 0, 0, 0, 0, 1, 1};
    logic        he[9] = '{0, 1, 1, 1, 0, 0, 1, 1, 0};
    int          pv[4] = '{50, 130, 50, 110};
    int          av[4] = '{150, 150, 50, 50};
    int          bv[4] = '{50, 150, 150, 150};
    logic        af[4] = '{1, 1, 1, 0};
    logic        ae[4] = '{0, 1, 0, 1};
    int          mv[5] = '{150, 150, 150, 50, 50};
    int          mm[5] = '{0, 1, 2, 2, 0};
    logic        me[5] = '{0, 1, 0, 1, 0};

    aoc_meas_model #(.NCH(2), .W(16)) i_meas (.sys_clk_i(sys_clk),
        .go_i(go), .req_val_i(req), .sample_o(sample), .value_o(val));
    aoc_top #(.NCH(2), .NOUT(2), .TICK_CYC(10)) i_dut (
        .sys_clk_i(sys_clk), .reset_n_i(reset_n), .sample_i(sample),
        .value_i(val), .thresh1_i(thr1), .thresh2_i(thr2), .hyst1_i(hy1),
        .hyst2_i(hy2), .first_alarm_direction_i(dir1),
        .second_alarm_direction_i(dir2), .mode_i(mode), .func_i(func),
        .source_i(src), .close_dly_i(cdly), .open_dly_i(odly),
        .close_hold_i(chold), .open_hold_i(ohold), .alarm1_o(al1),
        .alarm2_o(al2), .active_o(act), .contact_o(cont));

    function automatic logic f_src(input logic [2:0] s,
                                   input logic [1:0] p);
        case (s)
            3'h1: return p[0];
            3'h2: return p[1];
            3'h3: return p[0] | p[1];
            3'h4: return p[0] & p[1];
            default: return 1'b0;
        endcase
    endfunction

    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    task automatic meas(input int v0, input int v1);
        @(posedge sys_clk);
        req <= {v1[15:0], v0[15:0]};
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        cyc(6);
    endtask

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        close_out();
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        cyc(6);
        for (int i = 0; i < 9; i++) begin
            @(posedge sys_clk);
            dir1[0] <= hd[i];
            hy1[15:0] <= hh[i][15:0];
            meas(hv[i], 50);
            `CHK(al1[0], he[i])
        end
        @(posedge sys_clk);
        dir1[0] <= 1'b0;
        for (int s = 0; s < 5; s++) begin
            for (int p = 0; p < 4; p++) begin
                @(posedge sys_clk);
                src[2:0] <= 3'(s);
                dir2[0] <= (p != 0);
                meas(pv[p], 50);
                `CHK({al2[0], al1[0]}, 2'(p))
                `CHK(act[0], f_src(3'(s), 2'(p)))
            end
        end
        @(posedge sys_clk);
        dir2[0] <= 1'b0;
        src[5:0] <= 6'h11;
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            func[0] <= af[i];
            meas(av[i], bv[i]);
            `CHK(act[0], ae[i])
        end
        @(posedge sys_clk);
        thr2[31:16] <= 16'h8000;
        meas(50, 32767);
        `CHK(al1[1], 1'b0)
        `CHK(al2[1], 1'b1)
        @(posedge sys_clk);
        hy2[15:0] <= 16'h000A;
        meas(125, 50);
        `CHK(al2[0], 1'b0)
        meas(131, 50);
        `CHK(al2[0], 1'b1)
        meas(111, 50);
        `CHK(al2[0], 1'b1)
        @(posedge sys_clk);
        src[5:0] <= 6'h01;
        for (int i = 0; i < 5; i++) begin
            @(posedge sys_clk);
            mode[1:0] <= 2'(mm[i]);
            meas(mv[i], 50);
            `CHK(cont[0], me[i])
        end
        @(posedge sys_clk);
        src[8:6] <= 3'h1;
        cdly[19:10] <= 10'h003;
        chold[19:10] <= 10'h005;
        odly[19:10] <= 10'h002;
        ohold[19:10] <= 10'h00A;
        meas(150, 50);
        n = 8;
        while (act[1] !== 1'b1 && n < 60) begin
            cyc(1);
            n++;
        end
        `CHK((n >= 20 && n <= 40), 1'b1)
        meas(50, 50);
        cyc(20);
        `CHK(act[1], 1'b1)
        cyc(60);
        `CHK(act[1], 1'b0)
        @(posedge sys_clk);
        chold[19:10] <= 10'h000;
        cdly[19:10] <= 10'h000;
        meas(150, 50);
        `CHK(act[1], 1'b0)
        cyc(80);
        `CHK(act[1], 1'b1)
        @(posedge sys_clk);
        ohold[19:10] <= 10'h000;
        cdly[19:10] <= 10'h005;
        meas(50, 50);
        cyc(24);
        `CHK(act[1], 1'b0)
        // Off spells stay shorter than one tick so the count nets upward.
        repeat (12) begin
            meas(50, 50);
            meas(150, 50);
            cyc(7);
        end
        `CHK(act[1], 1'b1)
        `CHK(cont[1], 1'b1)
        close_out();
    end
endmodule

`default_nettype wire
